// ===== hw/hsc_cfg.svh
`ifndef HSC_CFG_SVH
`define HSC_CFG_SVH

// Register map
`define HSC_CTL_OFFSET 12'h408
`define HSC_ADDR_W 12
`define HSC_DATA_W 32

// Implemented control field, bits 11:0; everything above reads as zero
`define HSC_CTL_MASK 32'h0000_0FFF
`define HSC_CTL_RESET 32'h0000_0800
`define HSC_CTL_BITS 12

// Field positions
`define HSC_BIT_INV_ATTN_BUTTON 0
`define HSC_BIT_INV_PRESENCE 1
`define HSC_BIT_INV_POWER_FAULT 2
`define HSC_BIT_INV_LATCH 3
`define HSC_BIT_INV_ATTN_IND 4
`define HSC_BIT_INV_POWER_IND 5
`define HSC_BIT_INV_POWER_EN 6
`define HSC_BIT_INV_INTERLOCK 7
`define HSC_BIT_INV_POWER_GOOD 8
`define HSC_BIT_PRES_LSB 9
`define HSC_BIT_PRES_MSB 10
`define HSC_BIT_AUTO_OFF 11

// Slot count
`define HSC_NPORTS 2

`endif

// ===== hw/hsc_pkg.sv
`default_nettype none
package hsc_pkg;

  typedef enum logic [1:0] {
    HSC_PRES_BOTH = 2'h0,
    HSC_PRES_SIGNAL = 2'h1,
    HSC_PRES_ALWAYS = 2'h2,
    HSC_PRES_NEVER = 2'h3
  } hsc_pres_mode_t;

  // Bit 11 down to bit 0 of the control register
  typedef struct packed {
    logic latchOpenAutoPowerOff;
    hsc_pres_mode_t presenceReportSelect;
    logic invertPowerGoodIn;
    logic invertInterlockOut;
    logic invertPowerEnableOut;
    logic invertPowerIndicatorOut;
    logic invertAttnIndicatorOut;
    logic invertLatchSensorIn;
    logic invertPowerFaultIn;
    logic invertPresenceIn;
    logic invertAttnButtonIn;
  } hsc_ctl_t;

  // Raw slot sense pins, active low at default polarity
  typedef struct packed {
    logic attnButtonInN;
    logic presenceInN;
    logic powerFaultInN;
    logic latchSensorInN;
    logic slotPowerGoodInN;
  } hsc_pin_in_t;

  // Normalized status towards the hot-plug controller, 1 = asserted
  typedef struct packed {
    logic attnPressed;
    logic adapterPresent;
    logic powerFault;
    logic latchOpen;
    logic powerGood;
  } hsc_hpc_stat_t;

  // Normalized requests from the hot-plug controller, 1 = asserted
  typedef struct packed {
    logic attnIndicatorOn;
    logic powerIndicatorOn;
    logic interlockEngage;
    logic powerControllerControl;
  } hsc_hpc_ctl_t;

  // Slot output pins
  typedef struct packed {
    logic attnIndicatorOutN;
    logic powerIndicatorOutN;
    logic slotPowerEnableOut;
    logic interlockOut;
  } hsc_pin_out_t;

endpackage : hsc_pkg
`default_nettype wire

// ===== hw/hsc_slot_cond.sv
`include "hsc_cfg.svh"
`default_nettype none
module hsc_slot_cond (
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Configuration
  input wire hsc_pkg::hsc_ctl_t ctl,
  // Slot pins
  input wire hsc_pkg::hsc_pin_in_t pinIn,
  output hsc_pkg::hsc_pin_out_t pinOut,
  // Link and capability
  input wire logic rxDetect,
  input wire logic latchPresentCap,
  // Hot-plug controller side
  input wire hsc_pkg::hsc_hpc_ctl_t hpcCtl,
  output hsc_pkg::hsc_hpc_stat_t hpcStat
);
  import hsc_pkg::*;

  function automatic logic presence_decode(input hsc_pres_mode_t mode, input logic rx,
                                           input logic pd);
    case (mode)
      HSC_PRES_BOTH: presence_decode = rx | pd;
      HSC_PRES_SIGNAL: presence_decode = pd;
      HSC_PRES_ALWAYS: presence_decode = 1'h1;
      HSC_PRES_NEVER: presence_decode = 1'h0;
      default: presence_decode = 1'h0;
    endcase
  endfunction : presence_decode

  // Inversion sits right at the pins so the controller never sees board wiring
  wire logic attnSense = ~pinIn.attnButtonInN ^ ctl.invertAttnButtonIn;
  wire logic presSense = ~pinIn.presenceInN ^ ctl.invertPresenceIn;
  wire logic faultSense = ~pinIn.powerFaultInN ^ ctl.invertPowerFaultIn;
  wire logic latchSense = ~pinIn.latchSensorInN ^ ctl.invertLatchSensorIn;
  wire logic goodSense = ~pinIn.slotPowerGoodInN ^ ctl.invertPowerGoodIn;
  wire logic presReport = presence_decode(ctl.presenceReportSelect, rxDetect,
                                          presSense);

  // Auto power-off overrides the controller whatever it asks for
  wire logic autoOff = ctl.latchOpenAutoPowerOff & latchPresentCap & latchSense;
  wire logic powerOn = ~hpcCtl.powerControllerControl & ~autoOff;

  wire hsc_hpc_stat_t next_hpcStat = '{
    attnPressed: attnSense,
    adapterPresent: presReport,
    powerFault: faultSense,
    latchOpen: latchSense,
    powerGood: goodSense
  };

  wire hsc_pin_out_t next_pinOut = '{
    attnIndicatorOutN: ~hpcCtl.attnIndicatorOn ^ ctl.invertAttnIndicatorOut,
    powerIndicatorOutN: ~hpcCtl.powerIndicatorOn ^ ctl.invertPowerIndicatorOut,
    slotPowerEnableOut: powerOn ^ ctl.invertPowerEnableOut,
    interlockOut: hpcCtl.interlockEngage ^ ctl.invertInterlockOut
  };

  // The release edge itself still loads reset values, so checks wait one more edge
  logic rstDly;

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      hpcStat <= '0;
      pinOut <= 4'hC;
      rstDly <= 1'h1;
    end else begin
      hpcStat <= next_hpcStat;
      pinOut <= next_pinOut;
      rstDly <= 1'h0;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst || rstDly);

  sequence s_latch_open_armed;
    ctl.latchOpenAutoPowerOff && latchPresentCap && latchSense;
  endsequence

  a_attn_invert: assert property (
    ##1 hpcStat.attnPressed == ($past(pinIn.attnButtonInN) ~^ $past(ctl.invertAttnButtonIn)))
    else $error("attention button sense wrong");
  a_fault_invert: assert property (
    ##1 hpcStat.powerFault == ($past(pinIn.powerFaultInN) ~^ $past(ctl.invertPowerFaultIn)))
    else $error("power fault sense wrong");
  a_good_invert: assert property (
    ##1 hpcStat.powerGood == ($past(pinIn.slotPowerGoodInN) ~^ $past(ctl.invertPowerGoodIn)))
    else $error("power good sense wrong");
  a_pres_always: assert property (
    ctl.presenceReportSelect == HSC_PRES_ALWAYS |=> hpcStat.adapterPresent)
    else $error("presence not forced on");
  a_pres_never: assert property (
    ctl.presenceReportSelect == HSC_PRES_NEVER |=> !hpcStat.adapterPresent)
    else $error("presence not forced off");
  a_pres_both: assert property (
    ctl.presenceReportSelect == HSC_PRES_BOTH && rxDetect |=> hpcStat.adapterPresent)
    else $error("receiver detect ignored");
  a_auto_off: assert property (
    s_latch_open_armed |=> pinOut.slotPowerEnableOut == $past(ctl.invertPowerEnableOut))
    else $error("slot power not cut on open latch");
  a_power_follow: assert property (
    !ctl.latchOpenAutoPowerOff && !hpcCtl.powerControllerControl
      |=> pinOut.slotPowerEnableOut != $past(ctl.invertPowerEnableOut))
    else $error("slot power enable polarity wrong");
  a_attn_ind: assert property (
    ##1 pinOut.attnIndicatorOutN == ($past(hpcCtl.attnIndicatorOn) ~^
                                     $past(ctl.invertAttnIndicatorOut)))
    else $error("attention indicator polarity wrong");
  a_interlock: assert property (
    ##1 pinOut.interlockOut == ($past(hpcCtl.interlockEngage) ^ $past(ctl.invertInterlockOut)))
    else $error("interlock polarity wrong");

endmodule : hsc_slot_cond
`default_nettype wire

// ===== hw/hsc_hotplug_config.sv
// Our own choice: the strobed register port.
`include "hsc_cfg.svh"
`default_nettype none
// Contract
// - Invert sensed attention button level on every port when its control bit set.
// - Invert sensed presence detect level on every port when its control bit set.
// - Invert sensed power fault level on every port when its control bit set.
// - Invert sensed latch sensor level on every port when its control bit set.
// - Drive attention indicator inverted on every port when its control bit set.
// - Drive power indicator inverted on every port when its control bit set.
// - Drive slot power enable inverted on every port when its control bit set.
// - Drive interlock output inverted on every port when its control bit set.
// - Invert sensed power good level on every port when its control bit set.
// - Presence mode 0: receiver detect OR presence pin; mode 1: pin only.
// - Presence mode 2 always reports present; mode 3 never reports present.
// - Auto-off enabled and latch capability set: open latch cuts slot power.
// - Latch auto-off works whatever the power controller control bit says.
module hsc_hotplug_config #(
  parameter int NPORTS = `HSC_NPORTS
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Register port
  input wire logic [`HSC_ADDR_W-1:0] regAddr,
  input wire logic [`HSC_DATA_W-1:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [`HSC_DATA_W-1:0] regRdData,
  // Slot pins
  input wire hsc_pkg::hsc_pin_in_t [NPORTS-1:0] pinIn,
  output hsc_pkg::hsc_pin_out_t [NPORTS-1:0] pinOut,
  // Per-port link and capability state
  input wire logic [NPORTS-1:0] rxDetect,
  input wire logic [NPORTS-1:0] latchPresentCap,
  // Hot-plug controllers
  input wire hsc_pkg::hsc_hpc_ctl_t [NPORTS-1:0] hpcCtl,
  output hsc_pkg::hsc_hpc_stat_t [NPORTS-1:0] hpcStat
);
  import hsc_pkg::*;

  logic [`HSC_DATA_W-1:0] ctlWord;
  logic rstDly;

  wire logic ctlHit = (regAddr == `HSC_CTL_OFFSET);
  wire logic ctlWrite = regWrite & ctlHit;
  wire logic ctlRead = regRead & ctlHit;
  wire logic [`HSC_DATA_W-1:0] next_ctlWord = regWrData & `HSC_CTL_MASK;
  // Unmapped reads and idle cycles return zero so stale data never lingers
  wire logic [`HSC_DATA_W-1:0] next_regRdData = ctlRead ? ctlWord : '0;
  wire hsc_ctl_t ctl = hsc_ctl_t'(ctlWord[`HSC_CTL_BITS-1:0]);

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctlWord <= `HSC_CTL_RESET;
    end else if (ctlWrite) begin
      ctlWord <= next_ctlWord;
    end
  end

  // The release edge itself still loads reset values, so checks wait one more edge
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      regRdData <= '0;
      rstDly <= 1'h1;
    end else begin
      regRdData <= next_regRdData;
      rstDly <= 1'h0;
    end
  end

  // One shared control word fans out to every port
  for (genvar p = 0; p < NPORTS; p++) begin : g_port
    hsc_slot_cond u_cond (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .ctl(ctl),
      .pinIn(pinIn[p]),
      .pinOut(pinOut[p]),
      .rxDetect(rxDetect[p]),
      .latchPresentCap(latchPresentCap[p]),
      .hpcCtl(hpcCtl[p]),
      .hpcStat(hpcStat[p])
    );
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst || rstDly);

  sequence s_ctl_write;
    regWrite && ctlHit;
  endsequence

  sequence s_ctl_read;
    regRead && ctlHit;
  endsequence

  a_write_store: assert property (
    s_ctl_write |=> ctlWord == ($past(regWrData) & `HSC_CTL_MASK))
    else $error("control write not stored");
  a_ctl_hold: assert property (
    !(regWrite && ctlHit) |=> $stable(ctlWord))
    else $error("control word changed without write");
  a_read_back: assert property (
    s_ctl_read |=> regRdData == $past(ctlWord))
    else $error("control read data wrong");
  a_read_zero: assert property (
    !(regRead && ctlHit) |=> regRdData == '0)
    else $error("read data not zero outside a hit");
  a_reserved_zero: assert property (
    (ctlWord & ~`HSC_CTL_MASK) == '0)
    else $error("reserved bits set");
  a_write_then_read: assert property (
    s_ctl_write ##1 s_ctl_read |=> regRdData == ($past(regWrData, 2) & `HSC_CTL_MASK))
    else $error("write then read mismatch");
  a_pres_signal: assert property (
    ctl.presenceReportSelect == HSC_PRES_SIGNAL
      |=> hpcStat[0].adapterPresent == ($past(pinIn[0].presenceInN) ~^
                                        $past(ctl.invertPresenceIn)))
    else $error("presence signal mode wrong");
  a_pres_invert: assert property (
    ctl.presenceReportSelect == HSC_PRES_SIGNAL && ctl.invertPresenceIn
      |=> hpcStat[0].adapterPresent == $past(pinIn[0].presenceInN))
    else $error("presence inversion wrong");
  a_latch_invert: assert property (
    ##1 hpcStat[0].latchOpen == ($past(pinIn[0].latchSensorInN) ~^
                                 $past(ctl.invertLatchSensorIn)))
    else $error("latch sense wrong");
  a_power_ind: assert property (
    ##1 pinOut[0].powerIndicatorOutN == ($past(hpcCtl[0].powerIndicatorOn) ~^
                                         $past(ctl.invertPowerIndicatorOut)))
    else $error("power indicator polarity wrong");
  a_pcc_ignored: assert property (
    ctl.latchOpenAutoPowerOff && latchPresentCap[0] && !hpcCtl[0].powerControllerControl
      && hpcStat[0].latchOpen && (pinIn[0].latchSensorInN == $past(pinIn[0].latchSensorInN))
      && $stable(ctl)
      |=> pinOut[0].slotPowerEnableOut == $past(ctl.invertPowerEnableOut))
    else $error("auto power-off beaten by controller");

endmodule : hsc_hotplug_config
`default_nettype wire

// ===== test/hsc_slot_model.sv
`default_nettype none
module hsc_slot_model #(
  parameter int NPORTS = 2
) (
  // Intended slot state and board wiring
  input wire hsc_pkg::hsc_hpc_stat_t [NPORTS-1:0] slotState,
  input wire logic [4:0] wireInvert,
  // Sense pins towards the switch
  output var hsc_pkg::hsc_pin_in_t [NPORTS-1:0] pinIn
);
  timeunit 1ns;
  timeprecision 1ps;
  import hsc_pkg::*;
  // Pins are active low unless the board wiring flips them
  for (genvar p = 0; p < NPORTS; p++) begin : g_port
    assign pinIn[p] = hsc_pin_in_t'(~slotState[p] ^ wireInvert);
  end
endmodule : hsc_slot_model
`default_nettype wire

// ===== test/hsc_hotplug_config_bench.sv
`default_nettype none
module hsc_hotplug_config_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import hsc_pkg::*;
  logic core_clk, sys_rst, regWrite, regRead;
  logic [11:0] regAddr;
  logic [31:0] regWrData, regRdData, r, cfg;
  hsc_pin_in_t [1:0] pinIn;
  hsc_pin_out_t [1:0] pinOut;
  hsc_hpc_stat_t [1:0] slotState, hpcStat;
  hsc_hpc_ctl_t [1:0] hpcCtl;
  logic [1:0] rxDetect, latchPresentCap;
  logic [4:0] wireInvert;
  logic [8:0] ex;
  hsc_ctl_t ctl;
  logic [31:0] expQ[$];
  bit rdPend;
  int errCount, nTests, seed, i, p;

  hsc_hotplug_config #(.NPORTS(2)) i_dut (.core_clk(core_clk), .sys_rst(sys_rst),
    .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
    .regRdData(regRdData), .pinIn(pinIn), .pinOut(pinOut), .rxDetect(rxDetect),
    .latchPresentCap(latchPresentCap), .hpcCtl(hpcCtl), .hpcStat(hpcStat));
  hsc_slot_model #(.NPORTS(2)) i_slot (.slotState(slotState), .wireInvert(wireInvert),
    .pinIn(pinIn));

  always #10 core_clk = ~core_clk;

  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    nTests++;
    if (seen !== exp) begin
      $display("Error %s expected %h seen %h", nm, exp, seen);
      errCount++;
    end
  endtask : chk

  task automatic print_verdict();
    if (errCount == 0 && nTests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : print_verdict

  task automatic wr(logic [11:0] a, logic [31:0] d);
    regAddr <= a;
    regWrData <= d;
    regWrite <= 1'h1;
    @(posedge core_clk);
    regWrite <= 1'h0;
  endtask : wr

  // Expected data is queued here; the monitor below pops it a cycle later
  task automatic rd(logic [11:0] a, logic [31:0] exp);
    regAddr <= a;
    regRead <= 1'h1;
    expQ.push_back(exp);
    @(posedge core_clk);
    regRead <= 1'h0;
  endtask : rd

  function automatic logic [8:0] model_port(hsc_ctl_t c, hsc_pin_in_t pi, logic rx,
                                            logic cap, hsc_hpc_ctl_t h);
    hsc_hpc_stat_t s;
    hsc_pin_out_t o;
    s = hsc_hpc_stat_t'(~pi ^ {c.invertAttnButtonIn, c.invertPresenceIn,
        c.invertPowerFaultIn, c.invertLatchSensorIn, c.invertPowerGoodIn});
    case (c.presenceReportSelect)
      HSC_PRES_BOTH: s.adapterPresent = rx | s.adapterPresent;
      HSC_PRES_ALWAYS: s.adapterPresent = 1'b1;
      HSC_PRES_NEVER: s.adapterPresent = 1'b0;
      default: ;
    endcase
    o.attnIndicatorOutN = ~h.attnIndicatorOn ^ c.invertAttnIndicatorOut;
    o.powerIndicatorOutN = ~h.powerIndicatorOn ^ c.invertPowerIndicatorOut;
    o.slotPowerEnableOut = ~(h.powerControllerControl
        | (c.latchOpenAutoPowerOff & cap & s.latchOpen)) ^ c.invertPowerEnableOut;
    o.interlockOut = h.interlockEngage ^ c.invertInterlockOut;
    return {s, o};
  endfunction : model_port

  // Read data stands one cycle only, zero otherwise
  always @(negedge core_clk) begin
    if (rdPend) begin
      chk("regRdData", regRdData, expQ.pop_front());
    end else begin
      chk("regRdIdle", regRdData, 32'h0);
    end
    rdPend = regRead;
  end

  initial begin
    repeat (5000) @(posedge core_clk);
    errCount++;
    print_verdict();
  end

  initial begin
    core_clk = 1'b0;
    sys_rst = 1'b1;
    {regAddr, regWrData, regWrite, regRead} = '0;
    {slotState, wireInvert, rxDetect, latchPresentCap, hpcCtl} = '0;
    seed = 29;
    ctl = hsc_ctl_t'(12'h800);
    repeat (20) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
    rd(12'h408, 32'h00000800);
    // Back-to-back write then read; bits above the control field must drop
    wr(12'h408, 32'hFFFF_F5A5);
    rd(12'h408, 32'h0000_05A5);
    for (i = 0; i < 64; i++) begin
      cfg = $random(seed);
      cfg[10:9] = i[1:0];
      r = $random(seed);
      // Pass 5 aims the write at an unmapped place; it must not land
      wr((i == 5) ? 12'h40C : 12'h408, cfg);
      if (i != 5) ctl = hsc_ctl_t'(cfg[11:0]);
      slotState <= r[9:0];
      rxDetect <= r[11:10];
      latchPresentCap <= r[13:12];
      hpcCtl <= r[21:14];
      wireInvert <= r[26:22];
      repeat (2) @(posedge core_clk);
      @(negedge core_clk);
      for (p = 0; p < 2; p++) begin
        ex = model_port(ctl, pinIn[p], rxDetect[p], latchPresentCap[p], hpcCtl[p]);
        chk("hpcStat", 32'(hpcStat[p]), 32'(ex[8:4]));
        chk("pinOut", 32'(pinOut[p]), 32'(ex[3:0]));
      end
      @(posedge core_clk);
      rd((i == 7) ? 12'h400 : 12'h408, (i == 7) ? 32'h0 : {20'h0, ctl});
    end
    // Let the last read data be checked before reset clears it
    @(posedge core_clk);
    // Second reset in mid-run: pins go idle and the control word returns to default
    sys_rst <= 1'h1;
    @(negedge core_clk);
    chk("rstStat", 32'(hpcStat), 32'h0);
    chk("rstPins", 32'(pinOut), 32'h000000CC);
    @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
    rd(12'h408, 32'h00000800);
    repeat (3) @(posedge core_clk);
    print_verdict();
  end
endmodule : hsc_hotplug_config_bench
`default_nettype wire
